//--- logic/line_sync_pkg.sv
// constants and types for the line exposure sync control
package line_sync_pkg;
    localparam int CLK_HZ = 100_000_000;
    localparam int US_PER_S = 1_000_000;
    localparam int MS_PER_S = 1_000;
    localparam int CYC_PER_US = CLK_HZ / US_PER_S;
    localparam int CYC_PER_MS = CLK_HZ / MS_PER_S;
    localparam logic [12:0] LINE_HZ_MIN = 13'h0032;
    localparam logic [12:0] LINE_HZ_MAX = 13'h1BE6;
    localparam logic [14:0] EXP_US_MIN = 15'h000A;
    localparam logic [14:0] EXP_US_MAX = 15'h4E20;
    localparam logic [14:0] EXP_US_DEFAULT = 15'(US_PER_S / 7142 + 1);
    localparam logic [14:0] DIV_MIN = 15'h0001;
    localparam logic [14:0] LINES_MIN = 15'h0001;
    localparam logic [4:0] MODE_FRAME_EDGE = 5'h08;
    localparam logic [4:0] MODE_FRAME_LEVEL = 5'h10;
    localparam logic [2:0] MODE_FREE = 3'h0;
    localparam logic [2:0] MODE_READOUT = 3'h1;
    localparam logic [2:0] MODE_FREE_MAX = 3'h2;
    localparam logic [2:0] MODE_EXPOSURE = 3'h4;
    localparam logic [2:0] MODE_WINDOW = 3'h5;
    localparam logic ACK_OK = 1'b0;
    localparam logic ACK_FAIL = 1'b1;
    localparam logic [31:0] CNT_ONE = 32'h0000_0001;
    typedef enum logic [1:0] {FR_IDLE, FR_DELAY, FR_LINES} frame_state_e;
endpackage

//--- logic/settings_if.sv
// settings carrier between the control core and its storage
`timescale 1ns/1ps
interface settings_if;
    logic wr;
    logic [4:0] mode;
    logic [12:0] line_hz;
    logic [14:0] exp_us;
    logic [14:0] divider;
    logic [14:0] delay_ms;
    logic [14:0] lines;
    logic decouple;
    logic [4:0] q_mode;
    logic [12:0] q_line_hz;
    logic [14:0] q_exp_us;
    logic [14:0] q_divider;
    logic [14:0] q_delay_ms;
    logic [14:0] q_lines;
    logic q_decouple;
    modport core (output wr, mode, line_hz, exp_us, divider, delay_ms, lines, decouple,
        input q_mode, q_line_hz, q_exp_us, q_divider, q_delay_ms, q_lines, q_decouple);
    modport store (input wr, mode, line_hz, exp_us, divider, delay_ms, lines, decouple,
        output q_mode, q_line_hz, q_exp_us, q_divider, q_delay_ms, q_lines, q_decouple);
endinterface

//--- logic/settings_store.sv
// retained settings store, read data registered
`timescale 1ns/1ps
module settings_store (
    input wire logic i_ref_clk,
    input wire logic i_reset_n,
    settings_if.store s
);
    logic [4:0] mode, next_mode;
    logic [12:0] line_hz, next_line_hz;
    logic [14:0] exp_us, next_exp_us;
    logic [14:0] divider, next_divider;
    logic [14:0] delay_ms, next_delay_ms;
    logic [14:0] lines, next_lines;
    logic decouple, next_decouple;

    always_comb begin
        next_mode = mode;
        next_line_hz = line_hz;
        next_exp_us = exp_us;
        next_divider = divider;
        next_delay_ms = delay_ms;
        next_lines = lines;
        next_decouple = decouple;
        if (s.wr) begin
            next_mode = s.mode;
            next_line_hz = s.line_hz;
            next_exp_us = s.exp_us;
            next_divider = s.divider;
            next_delay_ms = s.delay_ms;
            next_lines = s.lines;
            next_decouple = s.decouple;
        end
    end

    // held over reset; only a write changes them
    always_ff @(posedge i_ref_clk) begin
        mode <= next_mode;
        line_hz <= next_line_hz;
        exp_us <= next_exp_us;
        divider <= next_divider;
        delay_ms <= next_delay_ms;
        lines <= next_lines;
        decouple <= next_decouple;
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_reset_n) begin
            s.q_mode <= 5'h00;
            s.q_line_hz <= line_sync_pkg::LINE_HZ_MIN;
            s.q_exp_us <= line_sync_pkg::EXP_US_DEFAULT;
            s.q_divider <= line_sync_pkg::DIV_MIN;
            s.q_delay_ms <= 15'h0000;
            s.q_lines <= line_sync_pkg::LINES_MIN;
            s.q_decouple <= 1'b0;
        end else begin
            s.q_mode <= mode;
            s.q_line_hz <= line_hz;
            s.q_exp_us <= exp_us;
            s.q_divider <= divider;
            s.q_delay_ms <= delay_ms;
            s.q_lines <= lines;
            s.q_decouple <= decouple;
        end
    end
endmodule

//--- logic/line_exposure_sync_control.sv
// line and frame exposure sequencing core
`timescale 1ns/1ps
module line_exposure_sync_control #(
    parameter logic HAS_SHUTTER = 1'b1
) (
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_reset_n,
    // trigger pins
    input wire logic i_line_trig_n,
    input wire logic i_frame_trig_n,
    // setting command
    input wire logic i_set_valid,
    input wire logic [4:0] i_set_mode,
    input wire logic [12:0] i_set_line_hz,
    input wire logic [14:0] i_set_exp_us,
    input wire logic i_set_exp_default,
    input wire logic [14:0] i_set_divider,
    input wire logic [14:0] i_set_delay_ms,
    input wire logic [14:0] i_set_lines,
    input wire logic i_set_decouple,
    // acknowledge
    output logic o_ack_valid,
    output logic o_ack_code,
    // sensor timing
    output logic o_scan_start_pulse,
    output logic o_exposing,
    output logic o_readout_pulse,
    output logic o_data_enable,
    output logic o_exposure_line_decoupling,
    output logic o_frame_active
);
    settings_if s ();

    settings_store u_store (
        .i_ref_clk(i_ref_clk),
        .i_reset_n(i_reset_n),
        .s(s)
    );

    function automatic logic [31:0] hz_to_cycles(input logic [12:0] hz);
        return 32'(line_sync_pkg::CLK_HZ / ((hz == 13'h0000) ? 1 : int'(hz)));
    endfunction

    // settings check and acknowledge
    logic bad;
    logic [14:0] exp_eff;
    always_comb begin
        exp_eff = i_set_exp_default ? line_sync_pkg::EXP_US_DEFAULT : i_set_exp_us;
        bad = 1'b0;
        unique case (i_set_mode[2:0])
            line_sync_pkg::MODE_FREE, line_sync_pkg::MODE_READOUT,
            line_sync_pkg::MODE_FREE_MAX, line_sync_pkg::MODE_WINDOW: bad = 1'b0;
            line_sync_pkg::MODE_EXPOSURE: bad = !HAS_SHUTTER;
            default: bad = 1'b1;
        endcase
        if ((i_set_mode & (line_sync_pkg::MODE_FRAME_EDGE | line_sync_pkg::MODE_FRAME_LEVEL))
            == (line_sync_pkg::MODE_FRAME_EDGE | line_sync_pkg::MODE_FRAME_LEVEL)) begin
            bad = 1'b1;
        end
        if (i_set_line_hz < line_sync_pkg::LINE_HZ_MIN ||
            i_set_line_hz > line_sync_pkg::LINE_HZ_MAX) begin
            bad = 1'b1;
        end
        if (exp_eff < line_sync_pkg::EXP_US_MIN || exp_eff > line_sync_pkg::EXP_US_MAX) begin
            bad = 1'b1;
        end
        if (i_set_divider < line_sync_pkg::DIV_MIN || i_set_lines < line_sync_pkg::LINES_MIN) begin
            bad = 1'b1;
        end
        s.wr = i_set_valid && !bad;
        s.mode = i_set_mode;
        s.line_hz = (i_set_mode[2:0] == line_sync_pkg::MODE_FREE_MAX) ?
            line_sync_pkg::LINE_HZ_MAX : i_set_line_hz;
        s.exp_us = exp_eff;
        s.divider = i_set_divider;
        s.delay_ms = i_set_delay_ms;
        s.lines = i_set_lines;
        s.decouple = i_set_decouple;
    end

    logic ack_valid, next_ack_valid, ack_code, next_ack_code;
    always_comb begin
        next_ack_valid = i_set_valid;
        next_ack_code = bad ? line_sync_pkg::ACK_FAIL : line_sync_pkg::ACK_OK;
    end

    // trigger synchronisers
    logic [1:0] line_meta, frame_meta;
    logic line_s, frame_s, line_d, frame_d;
    logic line_fall, frame_fall;
    always_ff @(posedge i_ref_clk) begin
        line_meta <= {line_meta[0], i_line_trig_n};
        frame_meta <= {frame_meta[0], i_frame_trig_n};
        line_d <= line_s;
        frame_d <= frame_s;
    end
    always_comb begin
        line_s = line_meta[1];
        frame_s = frame_meta[1];
        line_fall = line_d && !line_s;
        frame_fall = frame_d && !frame_s;
    end

    // trigger divider
    logic [14:0] div_cnt, next_div_cnt;
    logic trig;
    always_comb begin
        trig = 1'b0;
        next_div_cnt = div_cnt;
        if (line_fall) begin
            if (div_cnt + 15'h0001 >= s.q_divider) begin
                next_div_cnt = 15'h0000;
                trig = 1'b1;
            end else begin
                next_div_cnt = div_cnt + 15'h0001;
            end
        end
    end

    // line period and exposure timing
    logic [31:0] period, exp_cyc, line_cnt, next_line_cnt, exp_cnt, next_exp_cnt;
    logic exposing, next_exposing, trig_pend, next_trig_pend;
    logic scan_start_pulse, next_sos, rd, next_rd, decoupled, next_decoupled;
    logic line_tick;
    always_comb begin
        period = hz_to_cycles(s.q_line_hz);
        exp_cyc = 32'(s.q_exp_us) * 32'(line_sync_pkg::CYC_PER_US);
        next_decoupled = HAS_SHUTTER && (s.q_decouple || exp_cyc < period);
        line_tick = (line_cnt + line_sync_pkg::CNT_ONE >= period);
        next_line_cnt = line_tick ? 32'h0000_0000 : line_cnt + line_sync_pkg::CNT_ONE;
        next_exp_cnt = exp_cnt;
        next_exposing = exposing;
        next_trig_pend = trig_pend;
        next_sos = 1'b0;
        next_rd = 1'b0;
        if (exposing && exp_cnt != 32'h0000_0000) begin
            next_exp_cnt = exp_cnt - line_sync_pkg::CNT_ONE;
        end
        if (exposing && exp_cnt == line_sync_pkg::CNT_ONE && decoupled) begin
            next_exposing = 1'b0;
        end
        unique case (s.q_mode[2:0])
            line_sync_pkg::MODE_READOUT: begin
                if (trig) begin
                    next_trig_pend = 1'b1;
                end
                if (line_tick) begin
                    next_sos = 1'b1;
                    next_exposing = 1'b1;
                    next_exp_cnt = exp_cyc;
                    next_rd = trig_pend || trig;
                    next_trig_pend = 1'b0;
                end
            end
            line_sync_pkg::MODE_EXPOSURE: begin
                if (exposing && exp_cnt == line_sync_pkg::CNT_ONE) begin
                    next_rd = 1'b1;
                    next_exposing = 1'b0;
                end
                if (trig) begin
                    next_sos = 1'b1;
                    next_exposing = 1'b1;
                    next_exp_cnt = exp_cyc;
                    next_line_cnt = 32'h0000_0000;
                end
            end
            line_sync_pkg::MODE_WINDOW: begin
                if (trig) begin
                    next_sos = 1'b1;
                    next_rd = 1'b1;
                    next_exposing = 1'b1;
                    next_exp_cnt = 32'h0000_0000;
                end
            end
            default: begin
                if (line_tick) begin
                    next_sos = 1'b1;
                    next_rd = 1'b1;
                    next_exposing = 1'b1;
                    next_exp_cnt = exp_cyc;
                end
            end
        endcase
    end

    // frame gating
    line_sync_pkg::frame_state_e fstate, next_fstate;
    logic [31:0] delay_cnt, next_delay_cnt;
    logic [14:0] lines_left, next_lines_left;
    logic frame_on, data_en;
    always_comb begin
        frame_on = |(s.q_mode & (line_sync_pkg::MODE_FRAME_EDGE | line_sync_pkg::MODE_FRAME_LEVEL));
        next_fstate = fstate;
        next_delay_cnt = delay_cnt;
        next_lines_left = lines_left;
        unique case (fstate)
            line_sync_pkg::FR_IDLE: begin
                if ((s.q_mode & line_sync_pkg::MODE_FRAME_EDGE) != 5'h00 && frame_fall) begin
                    next_fstate = line_sync_pkg::FR_DELAY;
                    next_delay_cnt = 32'(s.q_delay_ms) * 32'(line_sync_pkg::CYC_PER_MS);
                end
            end
            line_sync_pkg::FR_DELAY: begin
                if (delay_cnt == 32'h0000_0000) begin
                    next_fstate = line_sync_pkg::FR_LINES;
                    next_lines_left = s.q_lines;
                end else begin
                    next_delay_cnt = delay_cnt - line_sync_pkg::CNT_ONE;
                end
            end
            line_sync_pkg::FR_LINES: begin
                if (rd) begin
                    next_lines_left = lines_left - 15'h0001;
                    if (lines_left == 15'h0001) begin
                        next_fstate = line_sync_pkg::FR_IDLE;
                    end
                end
            end
            default: next_fstate = line_sync_pkg::FR_IDLE;
        endcase
        if ((s.q_mode & line_sync_pkg::MODE_FRAME_EDGE) == 5'h00) begin
            next_fstate = line_sync_pkg::FR_IDLE;
        end
        if (!frame_on) begin
            data_en = 1'b1;
        end else if ((s.q_mode & line_sync_pkg::MODE_FRAME_LEVEL) != 5'h00) begin
            data_en = !frame_s;
        end else begin
            data_en = (fstate == line_sync_pkg::FR_LINES);
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_reset_n) begin
            ack_valid <= 1'b0;
            ack_code <= line_sync_pkg::ACK_OK;
            div_cnt <= 15'h0000;
            line_cnt <= 32'h0000_0000;
            exp_cnt <= 32'h0000_0000;
            exposing <= 1'b0;
            trig_pend <= 1'b0;
            scan_start_pulse <= 1'b0;
            rd <= 1'b0;
            decoupled <= 1'b0;
            fstate <= line_sync_pkg::FR_IDLE;
            delay_cnt <= 32'h0000_0000;
            lines_left <= 15'h0000;
        end else begin
            ack_valid <= next_ack_valid;
            ack_code <= next_ack_code;
            div_cnt <= next_div_cnt;
            line_cnt <= next_line_cnt;
            exp_cnt <= next_exp_cnt;
            exposing <= next_exposing;
            trig_pend <= next_trig_pend;
            scan_start_pulse <= next_sos;
            rd <= next_rd;
            decoupled <= next_decoupled;
            fstate <= next_fstate;
            delay_cnt <= next_delay_cnt;
            lines_left <= next_lines_left;
        end
    end

    // registered outputs
    always_ff @(posedge i_ref_clk) begin
        if (!i_reset_n) begin
            o_ack_valid <= 1'b0;
            o_ack_code <= line_sync_pkg::ACK_OK;
            o_scan_start_pulse <= 1'b0;
            o_exposing <= 1'b0;
            o_readout_pulse <= 1'b0;
            o_data_enable <= 1'b0;
            o_exposure_line_decoupling <= 1'b0;
            o_frame_active <= 1'b0;
        end else begin
            o_ack_valid <= ack_valid;
            o_ack_code <= ack_code;
            o_scan_start_pulse <= scan_start_pulse;
            o_exposing <= exposing;
            o_readout_pulse <= rd && data_en;
            o_data_enable <= data_en;
            o_exposure_line_decoupling <= decoupled;
            o_frame_active <= frame_on && data_en;
        end
    end
endmodule

//--- tb/line_sync_monitor.sv
// assertion checker for the line exposure sync control
`timescale 1ns/1ps
module line_sync_monitor (
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_reset_n,
    // inputs watched
    input wire logic i_line_trig_n,
    input wire logic i_set_valid,
    input wire logic [4:0] i_set_mode,
    input wire logic [14:0] i_set_divider,
    // outputs watched
    input wire logic o_ack_valid,
    input wire logic o_ack_code,
    input wire logic o_scan_start_pulse,
    input wire logic o_exposing,
    input wire logic o_readout_pulse,
    input wire logic o_data_enable,
    input wire logic o_frame_active
);
    logic [19:0] p1;
    logic [19:0] p2;
    logic [4:0] mode;
    logic [14:0] div;
    // applied settings, taken when acknowledged ok
    always_ff @(posedge i_ref_clk) begin
        p1 <= {i_set_mode, i_set_divider};
        p2 <= p1;
        if (!i_reset_n) begin
            mode <= 5'h00;
            div <= 15'h0001;
        end else if (o_ack_valid && !o_ack_code) begin
            mode <= p2[19:15];
            div <= p2[14:0];
        end
    end
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_reset_n);
    sequence quiet8;
        !o_readout_pulse [*8];
    endsequence
    sequence sos_soon;
        ##[2:7] o_scan_start_pulse;
    endsequence
    AST_ACK_LATENCY: assert property (i_set_valid |-> ##2 o_ack_valid)
        else $error("ack missing two cycles after set");
    AST_ACK_CAUSE: assert property (o_ack_valid |-> $past(i_set_valid, 2))
        else $error("ack without set");
    AST_BAD_FRAME: assert property (i_set_valid && i_set_mode[4:3] == 2'b11 |-> ##2 o_ack_code)
        else $error("both frame options accepted");
    AST_SOS_PULSE: assert property (o_scan_start_pulse |=> !o_scan_start_pulse)
        else $error("scan start longer than one cycle");
    AST_RD_GATED: assert property (o_readout_pulse |-> o_data_enable || $past(o_data_enable))
        else $error("readout with data disabled");
    AST_M5_SOS: assert property (mode == 5'h05 && div == 15'h0001 && $fell(i_line_trig_n) |-> sos_soon)
        else $error("no scan start after trigger");
    AST_M4_EXP: assert property (mode == 5'h04 && o_scan_start_pulse |-> ##[0:1] o_exposing)
        else $error("no exposure after scan start");
    AST_M4_WAIT: assert property (mode == 5'h04 && o_scan_start_pulse |=> quiet8)
        else $error("readout before exposure elapsed");
    AST_FRAME_MODE: assert property (o_frame_active |-> mode[4:3] != 2'b00 || $past(mode[4:3]) != 2'b00)
        else $error("frame active outside frame mode");
endmodule
bind line_exposure_sync_control line_sync_monitor u_line_sync_monitor (.i_ref_clk, .i_reset_n,
    .i_line_trig_n, .i_set_valid, .i_set_mode, .i_set_divider, .o_ack_valid, .o_ack_code,
    .o_scan_start_pulse, .o_exposing, .o_readout_pulse, .o_data_enable, .o_frame_active);

//--- tb/trig_source.sv
// external line and frame trigger source model
`timescale 1ns/1ps
module trig_source (
    // clock
    input wire logic i_ref_clk,
    // trigger pins, idle high
    output logic o_line_trig_n,
    output logic o_frame_trig_n
);
    initial begin
        o_line_trig_n = 1'b1;
        o_frame_trig_n = 1'b1;
    end
    // one low pulse, then high for the rest of the period
    task automatic line_pulse(input int period);
        int p;
        p = (period < 12) ? 12 : period;
        @(posedge i_ref_clk) #1 o_line_trig_n = 1'b0;
        repeat (4) @(posedge i_ref_clk);
        #1 o_line_trig_n = 1'b1;
        repeat (p - 5) @(posedge i_ref_clk);
    endtask
    task automatic frame_level(input logic lvl);
        @(posedge i_ref_clk) #1 o_frame_trig_n = lvl;
        repeat (4) @(posedge i_ref_clk);
    endtask
endmodule

//--- tb/test_line_exposure_sync_control.sv
// self-checking bench for the line exposure sync control
`timescale 1ns/1ps
module test_line_exposure_sync_control;
    logic i_ref_clk = 1'b0;
    logic i_reset_n = 1'b0;
    logic i_set_valid = 1'b0;
    logic [4:0] i_set_mode = 5'h00;
    logic [12:0] i_set_line_hz = 13'h0032;
    logic [14:0] i_set_exp_us = 15'h000A;
    logic i_set_exp_default = 1'b0;
    logic [14:0] i_set_divider = 15'h0001;
    logic [14:0] i_set_delay_ms = 15'h0000;
    logic [14:0] i_set_lines = 15'h0001;
    logic i_set_decouple = 1'b0;
    logic i_line_trig_n, i_frame_trig_n, o_ack_valid, o_ack_code, o_scan_start_pulse;
    logic o_exposing, o_readout_pulse, o_data_enable, o_exposure_line_decoupling, o_frame_active;
    int error_cnt = 0;
    int checks = 0;
    int cyc = 0;
    int rd_cnt = 0;
    int sos_cnt = 0;
    int sos_at = 0;
    int per;
    int rd_q[$];
    logic ack_q[$];
    int ml[5] = '{0, 1, 2, 4, 5};
    logic [31:0] seed = 32'h0000_C1A4;
    trig_source u_trig_source (.i_ref_clk, .o_line_trig_n(i_line_trig_n),
        .o_frame_trig_n(i_frame_trig_n));
    line_exposure_sync_control u_line_exposure_sync_control (.i_ref_clk, .i_reset_n,
        .i_line_trig_n, .i_frame_trig_n, .i_set_valid, .i_set_mode, .i_set_line_hz,
        .i_set_exp_us, .i_set_exp_default, .i_set_divider, .i_set_delay_ms, .i_set_lines,
        .i_set_decouple, .o_ack_valid, .o_ack_code, .o_scan_start_pulse, .o_exposing,
        .o_readout_pulse, .o_data_enable, .o_exposure_line_decoupling, .o_frame_active);
    always #5 i_ref_clk = ~i_ref_clk;
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    function automatic logic cfg_bad(input int m, hz, e, dv, ln);
        return !((m % 8) inside {0, 1, 2, 4, 5}) || m >= 24 || hz < 50 || hz > 7142
            || e < 10 || e > 20000 || dv < 1 || ln < 1;
    endfunction
    task automatic chk_bit(input logic got, input logic exp);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD %0t bit got %b want %b", $time, got, exp);
        end
    endtask
    task automatic chk_int(input int got, input int lo, input int hi);
        checks++;
        if (got < lo || got > hi) begin
            error_cnt++;
            $display("BAD %0t count %0d want %0d..%0d", $time, got, lo, hi);
        end
    endtask
    task automatic summarize;
        $display("errors %0d checks %0d", error_cnt, checks);
        if (error_cnt == 0 && checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // result monitor with expected ack queue
    always @(posedge i_ref_clk) begin
        cyc <= cyc + 1;
        if (i_reset_n && o_readout_pulse === 1'b1) begin
            rd_cnt <= rd_cnt + 1;
            rd_q.push_back(cyc);
        end
        if (i_reset_n && o_scan_start_pulse === 1'b1) begin
            sos_cnt <= sos_cnt + 1;
            sos_at <= cyc;
        end
        if (i_reset_n && o_ack_valid === 1'b1) begin
            if (ack_q.size() == 0) begin
                chk_bit(1'b1, 1'b0);
            end else begin
                chk_bit(o_ack_code, ack_q.pop_front());
            end
        end
    end
    task automatic set_cfg(input int m, hz, e, input logic d, input int dv, ln);
        ack_q.push_back(cfg_bad(m, hz, d ? 141 : e, dv, ln));
        i_set_valid = 1'b1;
        i_set_mode = 5'(m);
        i_set_line_hz = 13'(hz);
        i_set_exp_us = 15'(e);
        i_set_exp_default = d;
        i_set_divider = 15'(dv);
        i_set_lines = 15'(ln);
        i_set_delay_ms = (m >= 8) ? 15'h0000 : 15'(rnd());
        i_set_decouple = 1'(rnd() % 2);
        @(posedge i_ref_clk) #1;
    endtask
    task automatic idle(input int n);
        i_set_valid = 1'b0;
        repeat (n) @(posedge i_ref_clk);
        #1;
    endtask
    task automatic wait_rd(input int n, input int lim);
        int k;
        k = 0;
        while (rd_cnt < n && k < lim) begin
            @(posedge i_ref_clk);
            k++;
        end
        #1;
        if (rd_cnt < n) begin
            error_cnt++;
            $display("BAD %0t readout timeout", $time);
            summarize();
        end
    endtask
    task automatic clr;
        rd_cnt = 0;
        sos_cnt = 0;
        rd_q.delete();
    endtask
    initial begin
        // store loaded while reset is low, so no unknown settings leak out
        i_set_valid = 1'b1;
        @(posedge i_ref_clk) #1 i_set_valid = 1'b0;
        @(posedge i_ref_clk) #1 i_reset_n = 1'b1;
        chk_bit(o_data_enable, 1'b0);
        chk_bit(o_ack_valid, 1'b0);
        // back-to-back settings, refusals and every mode
        set_cfg(0, 50, 10, 0, 1, 1);
        set_cfg(24, 50, 10, 0, 1, 1);
        set_cfg(3, 50, 10, 0, 1, 1);
        set_cfg(5, 49, 10, 0, 1, 1);
        set_cfg(5, 7143, 10, 0, 1, 1);
        set_cfg(5, 50, 9, 0, 1, 1);
        set_cfg(5, 50, 20001, 0, 1, 1);
        set_cfg(5, 50, 10, 0, 0, 1);
        set_cfg(5, 50, 10, 0, 1, 0);
        for (int i = 0; i < 15; i++) begin
            set_cfg(ml[i % 5] + 8 * (i / 5), 50 + int'(rnd() % 7093), 10 + int'(rnd() % 19991),
                rnd() % 2 == 1, 1 + int'(rnd() % 4), 1 + int'(rnd() % 99));
        end
        idle(4);
        chk_int(ack_q.size(), 0, 0);
        // trigger-timed exposure, divider 1 then 3
        set_cfg(5, 50, 10, 0, 1, 1);
        idle(6);
        clr();
        repeat (6) u_trig_source.line_pulse(20 + int'(rnd() % 64));
        idle(8);
        chk_int(rd_cnt, 6, 6);
        chk_int(sos_cnt, 6, 6);
        set_cfg(5, 50, 10, 0, 3, 1);
        idle(6);
        clr();
        repeat (9) u_trig_source.line_pulse(20 + int'(rnd() % 64));
        idle(8);
        chk_int(sos_cnt, 3, 3);
        chk_int(rd_cnt, 3, 3);
        // exposure on trigger with default exposure
        set_cfg(4, 50, 10, 1, 1, 1);
        idle(6);
        clr();
        u_trig_source.line_pulse(20);
        wait_rd(1, 20000);
        per = int'(line_sync_pkg::EXP_US_DEFAULT) * line_sync_pkg::CYC_PER_US;
        chk_int(rd_q[0] - sos_at, per, per + 3);
        chk_bit(o_exposure_line_decoupling, 1'b1);
        // free run forced to maximum rate
        set_cfg(2, 50, 10, 0, 1, 1);
        idle(2);
        clr();
        wait_rd(2, 30000);
        per = line_sync_pkg::CLK_HZ / 7142;
        chk_int(rd_q[1] - rd_q[0], per - 1, per + 1);
        // readout on trigger at next internal tick, exposure above period
        set_cfg(1, 7142, 200, 0, 1, 1);
        idle(6);
        clr();
        chk_bit(o_exposure_line_decoupling, i_set_decouple);
        u_trig_source.line_pulse(20);
        wait_rd(1, 15000);
        chk_int(rd_q[0] - sos_at, 0, 0);
        // frame start on falling edge, three lines
        set_cfg(13, 50, 10, 0, 1, 3);
        idle(6);
        clr();
        repeat (3) u_trig_source.line_pulse(30);
        chk_int(rd_cnt, 0, 0);
        u_trig_source.frame_level(1'b0);
        u_trig_source.frame_level(1'b1);
        chk_bit(o_frame_active, 1'b1);
        repeat (5) u_trig_source.line_pulse(30);
        idle(4);
        chk_int(rd_cnt, 3, 3);
        chk_bit(o_data_enable, 1'b0);
        // level gated frame
        set_cfg(21, 50, 10, 0, 1, 100);
        idle(6);
        clr();
        repeat (2) u_trig_source.line_pulse(30);
        u_trig_source.frame_level(1'b0);
        repeat (4) u_trig_source.line_pulse(30);
        u_trig_source.frame_level(1'b1);
        repeat (2) u_trig_source.line_pulse(30);
        chk_int(rd_cnt, 4, 4);
        summarize();
    end
endmodule
